// ---- design/mtype_policy.sv ----
// memory-type policy sequencer between load/store pipe and caches
// assumes one request held stable until acc_done_o; acks are pulses
`default_nettype none

module mtype_policy
(
   input  wire logic                          mclk_i,
   input  wire logic                          arst_n_i,
   // access request
   input  wire logic                          acc_valid_i,
   output logic                               acc_ready_o,
   input  wire logic                          acc_write_i,
   input  wire logic                          acc_fetch_i,
   input  wire logic                          acc_locked_i,
   input  wire logic [mtype_pkg::ADDR_W-1:0]  acc_addr_i,
   input  wire logic [mtype_pkg::SIZE_W-1:0]  acc_size_i,
   input  wire logic [2:0]                    page_attr_type_i,
   input  wire logic [2:0]                    range_type_i,
   // core control events
   input  wire logic                          cache_disable_control_bit_i,
   input  wire logic                          cache_invalidate_no_writeback_i,
   input  wire logic                          cache_flush_and_invalidate_i,
   input  wire logic                          single_page_translation_invalidate_i,
   input  wire logic                          page_table_base_write_i,
   output logic                               tlb_drop_page_o,
   output logic                               tlb_drop_all_o,
   // cache lookup result for the held access
   input  wire logic                          dcache_hit_i,
   input  wire logic                          icache_hit_i,
   input  wire logic [2:0]                    line_state_i,
   // store buffer and combining buffer
   input  wire logic                          wbuf_empty_i,
   output logic                               wbuf_drain_o,
   output logic                               comb_flush_o,
   // invalidation of hit lines in all caches
   output logic                               inval_req_o,
   output logic                               inval_writeback_o,
   input  wire logic                          inval_done_i,
   // resulting memory action
   output logic                               mem_issue_o,
   input  wire logic                          mem_ack_i,
   output logic [2:0]                         eff_type_o,
   output logic                               use_cache_o,
   output logic                               alloc_o,
   output logic [2:0]                         new_state_o,
   output logic                               mem_write_o,
   output logic                               to_comb_buf_o,
   output logic                               to_store_buf_o,
   output logic                               probe_all_o,
   output logic                               bus_lock_o,
   output logic                               split_o,
   output logic                               acc_done_o
);

   // ==========================================================
   // effective type and atomicity
   logic caches_stale_q;
   logic cd_bit_q;
   logic [2:0] req_type;
   logic rd_cacheable;
   logic rd_allocate;
   logic wr_allocate;
   logic wr_upd_line;
   logic wr_hit_inval;
   logic wr_to_mem;
   logic spec_ok;
   logic buf_ok;
   logic comb_ok;
   logic probe_all;
   logic strict_order;
   logic drain_first;

   function automatic logic fits_qword(input logic [mtype_pkg::ADDR_W-1:0] addr,
                                       input logic [mtype_pkg::SIZE_W-1:0] size);
      logic [mtype_pkg::QWORD_LSB_W:0] end_off;
      end_off = {1'b0, addr[mtype_pkg::QWORD_LSB_W-1:0]}
                + size[mtype_pkg::QWORD_LSB_W:0];
      fits_qword = (size != 4'h0) && (end_off <= 4'h8);
   endfunction : fits_qword

   function automatic logic is_cacheable(input logic [2:0] t);
      is_cacheable = (t == mtype_pkg::write_protect_type)
                     || (t == mtype_pkg::write_through_type)
                     || (t == mtype_pkg::write_back_type);
   endfunction : is_cacheable

   // cache-disabled inference: disabled without invalidate, or attribute conflict
   always_comb
   begin
      if (page_attr_type_i != range_type_i)
         req_type = mtype_pkg::cache_disabled_type;
      else if (caches_stale_q && is_cacheable(page_attr_type_i))
         req_type = mtype_pkg::cache_disabled_type;
      else
         req_type = page_attr_type_i;
   end

   // caches go stale when the disable bit rises and stay so until an invalidate or the bit falls;
   // a rise in the same cycle as an invalidate wins, so stale data is never trusted
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         caches_stale_q <= 1'b0;
      else if (!cache_disable_control_bit_i)
         caches_stale_q <= 1'b0;
      else if (!cd_bit_q)
         caches_stale_q <= 1'b1;
      else if (cache_invalidate_no_writeback_i || cache_flush_and_invalidate_i)
         caches_stale_q <= 1'b0;
   end

   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         cd_bit_q <= 1'b0;
      else
         cd_bit_q <= cache_disable_control_bit_i;
   end

   // ==========================================================
   // translation drop, one cycle after the event
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         tlb_drop_page_o <= 1'b0;
         tlb_drop_all_o  <= 1'b0;
      end
      else
      begin
         tlb_drop_page_o <= single_page_translation_invalidate_i;
         tlb_drop_all_o  <= page_table_base_write_i;
      end
   end

   // ==========================================================
   // sequencer
   mtype_pkg::seq_state_t st_q;
   mtype_pkg::seq_state_t st_d;
   logic [2:0] type_q;
   logic       need_inval;
   logic       tlb_busy;

   mtype_decode u_decode
   (
      .mtype_i           (type_q),
      .rd_cacheable_o    (rd_cacheable),
      .rd_allocate_o     (rd_allocate),
      .wr_allocate_o     (wr_allocate),
      .wr_updates_line_o (wr_upd_line),
      .wr_hit_inval_o    (wr_hit_inval),
      .wr_to_memory_o    (wr_to_mem),
      .speculative_ok_o  (spec_ok),
      .buffering_ok_o    (buf_ok),
      .combining_ok_o    (comb_ok),
      .probe_all_o       (probe_all),
      .strict_order_o    (strict_order),
      .drain_first_o     (drain_first)
   );

   // cd data hits and wp/icache write hits invalidate before the access
   always_comb
   begin
      need_inval = 1'b0;
      if (type_q == mtype_pkg::cache_disabled_type)
         need_inval = acc_fetch_i ? 1'b0 : (dcache_hit_i || (acc_write_i && icache_hit_i));
      else if (wr_hit_inval && acc_write_i)
         need_inval = dcache_hit_i || icache_hit_i;
   end

   // a pending translation drop holds new accesses off one cycle
   assign tlb_busy    = single_page_translation_invalidate_i || page_table_base_write_i;
   assign acc_ready_o = (st_q == mtype_pkg::st_idle) && !tlb_busy;

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         mtype_pkg::st_idle:
            if (acc_valid_i && !tlb_busy)
               st_d = mtype_pkg::st_drain;
         mtype_pkg::st_drain:
            // strictly ordered types wait for an empty store buffer
            if (!drain_first || wbuf_empty_i)
               st_d = need_inval ? mtype_pkg::st_inval : mtype_pkg::st_issue;
         mtype_pkg::st_inval:
            // the access must not see the cache until the line is gone
            if (inval_done_i)
               st_d = mtype_pkg::st_issue;
         mtype_pkg::st_issue:
            if (mem_ack_i)
               st_d = mtype_pkg::st_done;
         mtype_pkg::st_done:
            st_d = mtype_pkg::st_idle;
         default:
            st_d = mtype_pkg::st_idle;
      endcase
   end

   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         st_q <= mtype_pkg::st_idle;
      else
         st_q <= st_d;
   end

   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         type_q <= mtype_pkg::uncacheable_type;
      else if (st_q == mtype_pkg::st_idle && acc_valid_i && !tlb_busy)
         type_q <= (req_type == mtype_pkg::reserved_type)
                   ? mtype_pkg::uncacheable_type : req_type;
   end

   assign wbuf_drain_o      = (st_q == mtype_pkg::st_drain) && drain_first && !wbuf_empty_i;
   assign comb_flush_o      = (st_q == mtype_pkg::st_drain) && drain_first;
   assign inval_req_o       = (st_q == mtype_pkg::st_inval);
   assign inval_writeback_o = (st_q == mtype_pkg::st_inval)
                              && (line_state_i == mtype_pkg::line_modified
                                  || line_state_i == mtype_pkg::line_owned);
   assign mem_issue_o       = (st_q == mtype_pkg::st_issue);

   // ==========================================================
   // registered policy outputs, captured as the access issues
   logic hit;
   logic [2:0] state_nx;
   logic cache_nx;
   logic alloc_nx;

   assign hit = acc_fetch_i ? icache_hit_i : dcache_hit_i;

   always_comb
   begin
      cache_nx = 1'b0;
      alloc_nx = 1'b0;
      state_nx = line_state_i;
      if (type_q == mtype_pkg::cache_disabled_type)
      begin
         cache_nx = acc_fetch_i && icache_hit_i;
         alloc_nx = 1'b0;
      end
      else if (!acc_write_i)
      begin
         cache_nx = rd_cacheable;
         alloc_nx = rd_allocate && !hit;
         if (alloc_nx)
            state_nx = mtype_pkg::line_exclusive;
         // read hits leave the line state alone
      end
      else if (wr_upd_line && hit)
      begin
         cache_nx = 1'b1;
         if (wr_to_mem)
            state_nx = line_state_i;
         else
            state_nx = mtype_pkg::line_modified;
      end
      else if (wr_allocate)
      begin
         cache_nx = 1'b1;
         alloc_nx = 1'b1;
         state_nx = mtype_pkg::line_modified;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         eff_type_o     <= mtype_pkg::uncacheable_type;
         use_cache_o    <= 1'b0;
         alloc_o        <= 1'b0;
         new_state_o    <= mtype_pkg::line_invalid;
         mem_write_o    <= 1'b0;
         to_comb_buf_o  <= 1'b0;
         to_store_buf_o <= 1'b0;
         probe_all_o    <= 1'b0;
         bus_lock_o     <= 1'b0;
         split_o        <= 1'b0;
      end
      else if (st_d == mtype_pkg::st_issue && st_q != mtype_pkg::st_issue)
      begin
         eff_type_o     <= type_q;
         use_cache_o    <= cache_nx;
         alloc_o        <= alloc_nx;
         new_state_o    <= state_nx;
         mem_write_o    <= acc_write_i && wr_to_mem;
         // combining storage is its own path, never the store buffer
         to_comb_buf_o  <= acc_write_i && comb_ok;
         to_store_buf_o <= acc_write_i && buf_ok && !comb_ok;
         probe_all_o    <= probe_all;
         // locked or exchange accesses hold the fabric for the whole access
         bus_lock_o     <= acc_locked_i;
         split_o        <= !fits_qword(acc_addr_i, acc_size_i) && !acc_locked_i;
      end
   end

   // speculation permission is a plain decode; unused by the sequencer itself
   logic spec_unused;
   assign spec_unused = spec_ok || strict_order;

   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         acc_done_o <= 1'b0;
      else
         acc_done_o <= (st_q == mtype_pkg::st_issue) && mem_ack_i;
   end

endmodule : mtype_policy

`default_nettype wire

// ---- design/mtype_pkg.sv ----
// memory-type policy constants, encodings and states
// assumes one core clock domain; no software-visible registers
`default_nettype none

package mtype_pkg;

   // ==========================================================
   // memory type encodings
   typedef enum logic [2:0]
   {
      uncacheable_type        = 3'h0,
      cache_disabled_type     = 3'h1,
      write_combining_type    = 3'h2,
      coherent_combining_type = 3'h3,
      write_protect_type      = 3'h4,
      write_through_type      = 3'h5,
      write_back_type         = 3'h6,
      reserved_type           = 3'h7
   } mem_type_t;

   // ==========================================================
   // coherence states
   typedef enum logic [2:0]
   {
      line_invalid   = 3'h0,
      line_shared    = 3'h1,
      line_exclusive = 3'h2,
      line_owned     = 3'h3,
      line_modified  = 3'h4
   } line_state_t;

   // ==========================================================
   // sequencer states, one-hot
   typedef enum logic [4:0]
   {
      st_idle  = 5'h01,
      st_drain = 5'h02,
      st_inval = 5'h04,
      st_issue = 5'h08,
      st_done  = 5'h10
   } seq_state_t;

   // ==========================================================
   // sizes and positions
   localparam int          ADDR_W       = 48;
   localparam int          SIZE_W       = 4;
   localparam int          QWORD_BYTES  = 8;
   localparam int          QWORD_LSB_W  = 3;
   localparam int          COMB_SLOTS   = 4;
   localparam int          COMB_SLOT_W  = 2;
   localparam logic [3:0]  RST_COMB_CNT = 4'h0;

endpackage : mtype_pkg

`default_nettype wire

// ---- design/mtype_decode.sv ----
// per-access policy decode for one memory type
// assumes effective type already resolved by the parent
`default_nettype none

module mtype_decode
(
   input  wire logic [2:0] mtype_i,
   output logic            rd_cacheable_o,
   output logic            rd_allocate_o,
   output logic            wr_allocate_o,
   output logic            wr_updates_line_o,
   output logic            wr_hit_inval_o,
   output logic            wr_to_memory_o,
   output logic            speculative_ok_o,
   output logic            buffering_ok_o,
   output logic            combining_ok_o,
   output logic            probe_all_o,
   output logic            strict_order_o,
   output logic            drain_first_o
);

   always_comb
   begin
      rd_cacheable_o    = 1'b0;
      rd_allocate_o     = 1'b0;
      wr_allocate_o     = 1'b0;
      wr_updates_line_o = 1'b0;
      wr_hit_inval_o    = 1'b0;
      wr_to_memory_o    = 1'b1;
      speculative_ok_o  = 1'b0;
      buffering_ok_o    = 1'b0;
      combining_ok_o    = 1'b0;
      probe_all_o       = 1'b0;
      strict_order_o    = 1'b0;
      drain_first_o     = 1'b0;
      case (mtype_i)
         mtype_pkg::uncacheable_type:
         begin
            strict_order_o = 1'b1;
            drain_first_o  = 1'b1;
         end
         mtype_pkg::cache_disabled_type:
         begin
            strict_order_o = 1'b1;
            drain_first_o  = 1'b1;
            wr_hit_inval_o = 1'b1;
            probe_all_o    = 1'b1;
         end
         mtype_pkg::write_combining_type:
         begin
            speculative_ok_o = 1'b1;
            combining_ok_o   = 1'b1;
         end
         mtype_pkg::coherent_combining_type:
         begin
            combining_ok_o = 1'b1;
            probe_all_o    = 1'b1;
         end
         mtype_pkg::write_protect_type:
         begin
            rd_cacheable_o   = 1'b1;
            rd_allocate_o    = 1'b1;
            speculative_ok_o = 1'b1;
            wr_hit_inval_o   = 1'b1;
            buffering_ok_o   = 1'b1;
         end
         mtype_pkg::write_through_type:
         begin
            rd_cacheable_o    = 1'b1;
            rd_allocate_o     = 1'b1;
            speculative_ok_o  = 1'b1;
            wr_updates_line_o = 1'b1;
            buffering_ok_o    = 1'b1;
         end
         mtype_pkg::write_back_type:
         begin
            rd_cacheable_o    = 1'b1;
            rd_allocate_o     = 1'b1;
            speculative_ok_o  = 1'b1;
            wr_allocate_o     = 1'b1;
            wr_updates_line_o = 1'b1;
            wr_to_memory_o    = 1'b0;
            buffering_ok_o    = 1'b1;
         end
         default:
         begin
            // reserved encoding handled as the safest type
            strict_order_o = 1'b1;
            drain_first_o  = 1'b1;
         end
      endcase
   end

endmodule : mtype_decode

`default_nettype wire

// ---- verif/mtype_monitor.sv ----
// checker for the memory-type policy outputs, watching top ports only
// assumes one clock domain; bound onto mtype_policy below
`default_nettype none

module mtype_monitor
(
   input wire logic       mclk_i,
   input wire logic       arst_n_i,
   input wire logic       acc_valid_i,
   input wire logic       acc_write_i,
   input wire logic       acc_locked_i,
   input wire logic [2:0] page_attr_type_i,
   input wire logic [2:0] range_type_i,
   input wire logic       single_page_translation_invalidate_i,
   input wire logic       page_table_base_write_i,
   input wire logic       tlb_drop_page_o,
   input wire logic       tlb_drop_all_o,
   input wire logic       wbuf_empty_i,
   input wire logic       inval_req_o,
   input wire logic       inval_done_i,
   input wire logic       mem_issue_o,
   input wire logic [2:0] eff_type_o,
   input wire logic       use_cache_o,
   input wire logic       alloc_o,
   input wire logic [2:0] new_state_o,
   input wire logic       mem_write_o,
   input wire logic       to_comb_buf_o,
   input wire logic       to_store_buf_o,
   input wire logic       probe_all_o,
   input wire logic       split_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   // ==========================================================
   // issue steps, by effective type
   sequence s_issue(logic [2:0] t);
      mem_issue_o && eff_type_o == t;
   endsequence
   sequence s_issue_wr(logic [2:0] t);
      mem_issue_o && acc_write_i && eff_type_o == t;
   endsequence

   a_page_drop: assert property (single_page_translation_invalidate_i |=> tlb_drop_page_o)
      else $error("page translation drop missing");
   a_all_drop: assert property (page_table_base_write_i |=> tlb_drop_all_o)
      else $error("full translation drop missing");
   a_uc_drained: assert property (s_issue(3'h0) |-> wbuf_empty_i)
      else $error("uncacheable issued with store buffer pending");
   a_uc_no_cache: assert property (s_issue(3'h0) |-> !use_cache_o && !alloc_o && !to_comb_buf_o)
      else $error("uncacheable access cached or combined");
   a_comb_no_cache: assert property (s_issue(3'h2) |-> !use_cache_o && !alloc_o)
      else $error("combining access cached");
   a_coh_probe: assert property (s_issue(3'h3) |-> probe_all_o && !use_cache_o)
      else $error("coherent combining access without probe");
   a_buf_apart: assert property (!(to_comb_buf_o && to_store_buf_o))
      else $error("combining and store buffer both chosen");
   a_wb_write_mod: assert property (s_issue_wr(3'h6) |-> new_state_o == 3'h4 && !mem_write_o)
      else $error("write-back write not marked modified");
   a_wt_write_mem: assert property (s_issue_wr(3'h5) |-> mem_write_o && !alloc_o)
      else $error("write-through write missed memory");
   a_wp_write_mem: assert property (s_issue_wr(3'h4) |-> mem_write_o && !alloc_o)
      else $error("write-protect write missed memory");
   a_inval_wait: assert property (inval_req_o && !inval_done_i |=> !mem_issue_o)
      else $error("issue before invalidation finished");
   a_conflict_cd: assert property (mem_issue_o && acc_valid_i && page_attr_type_i != range_type_i
      |-> eff_type_o == 3'h1)
      else $error("type conflict not cache-disabled");
   a_locked_whole: assert property (mem_issue_o && acc_locked_i |-> !split_o)
      else $error("locked access split");
endmodule : mtype_monitor

bind mtype_policy mtype_monitor mon_u (.mclk_i, .arst_n_i, .acc_valid_i, .acc_write_i,
   .acc_locked_i, .page_attr_type_i, .range_type_i, .single_page_translation_invalidate_i,
   .page_table_base_write_i, .tlb_drop_page_o, .tlb_drop_all_o, .wbuf_empty_i, .inval_req_o,
   .inval_done_i, .mem_issue_o, .eff_type_o, .use_cache_o, .alloc_o, .new_state_o,
   .mem_write_o, .to_comb_buf_o, .to_store_buf_o, .probe_all_o, .split_o);

`default_nettype wire

// ---- verif/mtype_fabric_model.sv ----
// store buffer, cache invalidation and memory fabric on the far side
// assumes one access at a time; answers are one-cycle pulses
`default_nettype none

module mtype_fabric_model
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic slow_i,
   input  wire logic fill_i,
   input  wire logic drain_i,
   input  wire logic inval_req_i,
   input  wire logic issue_i,
   output logic      empty_o,
   output logic      inval_done_o,
   output logic      ack_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int pend_q;
   int wait_q;

   assign empty_o = (pend_q == 0);

   // ==========================================================
   // entries leave only while drained, so a skipped drain shows up
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
         pend_q <= 0;
      else if (fill_i)
         pend_q <= pend_q + 3;
      else if (drain_i && pend_q > 0)
         pend_q <= pend_q - 1;

   // answers come at once or after a stall of a few cycles
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         wait_q <= 0;
         inval_done_o <= 1'b0;
         ack_o <= 1'b0;
      end
      else
      begin
         inval_done_o <= 1'b0;
         ack_o <= 1'b0;
         if ((inval_req_i || issue_i) && !inval_done_o && !ack_o)
         begin
            wait_q <= wait_q + 1;
            if (wait_q >= (slow_i ? 3 : 0))
            begin
               wait_q <= 0;
               inval_done_o <= inval_req_i;
               ack_o <= issue_i;
            end
         end
      end
endmodule : mtype_fabric_model

`default_nettype wire

// ---- verif/tb_memory_type_cache_policy.sv ----
// self-checking bench for the memory-type policy sequencer
// assumes mtype_fabric_model answers drains, invalidations and issues
`default_nettype none

module tb_memory_type_cache_policy;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_i = 0, arst_n_i = 0, acc_valid_i = 0, acc_write_i = 0, acc_fetch_i = 0;
   logic acc_locked_i = 0, cache_disable_control_bit_i = 0, cache_invalidate_no_writeback_i = 0;
   logic cache_flush_and_invalidate_i = 0, single_page_translation_invalidate_i = 0;
   logic page_table_base_write_i = 0, dcache_hit_i = 0, icache_hit_i = 0, slow_q = 0, fill_q = 0;
   logic [47:0] acc_addr_i = '0;
   logic [3:0] acc_size_i = 4'h1;
   logic [2:0] page_attr_type_i = '0, range_type_i = '0, line_state_i = '0;
   logic acc_ready_o, tlb_drop_page_o, tlb_drop_all_o, wbuf_empty_i, wbuf_drain_o, comb_flush_o;
   logic inval_req_o, inval_writeback_o, inval_done_i, mem_issue_o, mem_ack_i, use_cache_o;
   logic alloc_o, mem_write_o, to_comb_buf_o, to_store_buf_o, probe_all_o, bus_lock_o, split_o;
   logic acc_done_o;
   logic [2:0] eff_type_o, new_state_o;
   int seed = 17203, err_total = 0, checked = 0;

   always #2.5 mclk_i = ~mclk_i;

   mtype_policy dut_u (.*);

   mtype_fabric_model fab_u (.clk_i(mclk_i), .rst_n_i(arst_n_i), .slow_i(slow_q), .fill_i(fill_q),
      .drain_i(wbuf_drain_o), .inval_req_i(inval_req_o), .issue_i(mem_issue_o),
      .empty_o(wbuf_empty_i), .inval_done_o(inval_done_i), .ack_o(mem_ack_i));

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   // one control event; k picks page drop, full drop, flush, invalidate
   task automatic pulse_evt(input int k);
      @(negedge mclk_i);
      single_page_translation_invalidate_i = (k == 0);
      page_table_base_write_i = (k == 1);
      cache_flush_and_invalidate_i = (k == 2);
      cache_invalidate_no_writeback_i = (k == 3);
      #1;
      check(acc_ready_o, k >= 2);
      @(negedge mclk_i);
      check(tlb_drop_page_o, k == 0);
      check(tlb_drop_all_o, k == 1);
      {single_page_translation_invalidate_i, page_table_base_write_i} = 2'h0;
      {cache_flush_and_invalidate_i, cache_invalidate_no_writeback_i} = 2'h0;
   endtask : pulse_evt

   // one access held to completion, then its policy compared with values worked out from its arguments
   task automatic access(input int t, input bit conf, wr, fe, ht, lk, cdi);
      int n;
      int eff;
      int st;
      bit sd;
      bit si;
      bit sw;
      bit sc;
      bit fil;
      fil = 1'($random(seed));
      @(negedge mclk_i);
      fill_q = fil;
      slow_q = 1'($random(seed));
      @(negedge mclk_i);
      fill_q = 0;
      eff = (conf || (cdi && t >= 4 && t <= 6)) ? 1 : (t == 7 ? 0 : t);
      st = ht ? 1 + $unsigned($random(seed)) % 4 : 0;
      page_attr_type_i = 3'(t);
      range_type_i = conf ? 3'(t ^ 1) : 3'(t);
      acc_write_i = wr;
      acc_fetch_i = fe && !wr;
      acc_locked_i = lk;
      dcache_hit_i = ht && !acc_fetch_i;
      icache_hit_i = ht && acc_fetch_i;
      line_state_i = 3'(st);
      acc_addr_i = {16'($random(seed)), 32'($random(seed))};
      acc_size_i = 4'(1 + $unsigned($random(seed)) % 8);
      acc_valid_i = 1;
      {sd, si, sw, sc} = 4'h0;
      for (n = 0; n < 60 && acc_done_o !== 1'b1; n++)
      begin
         @(negedge mclk_i);
         sd |= wbuf_drain_o;
         si |= inval_req_o;
         sw |= inval_writeback_o;
         sc |= comb_flush_o;
      end
      if (n == 60) err_total++;
      acc_valid_i = 0;
      check(eff_type_o, eff);
      check(alloc_o, !ht && ((!wr && eff >= 4) || (wr && eff == 6)));
      check(mem_write_o, wr && eff != 6);
      check(to_comb_buf_o, wr && (eff == 2 || eff == 3));
      if (eff >= 2) check(probe_all_o, eff == 3);
      check(split_o, !lk && (acc_addr_i[2:0] + acc_size_i > 8));
      check(bus_lock_o, lk);
      check(to_store_buf_o, wr && eff >= 4);
      check(sc, eff <= 1);
      if (eff >= 2) check(sd, 0);
      if (eff == 1 && acc_fetch_i) check(use_cache_o, ht);
      check(use_cache_o, eff == 1 ? acc_fetch_i && ht
         : (wr ? (eff == 6 || (eff == 5 && ht)) : eff >= 4));
      if (eff == 1 || eff >= 4) check(si, ht && ((eff == 1 && !acc_fetch_i) || (eff == 4 && wr)));
      if (si) check(sw, st >= 3);
      if (fil && eff <= 1) check(sd, 1);
      if (wr && eff == 6) check(new_state_o, 4);
      else if (ht && !wr && eff >= 4) check(new_state_o, st);
      else if (ht && wr && eff == 5) check(new_state_o, st);
      else if (!ht && !wr && eff == 6) check(new_state_o, 2);
   endtask : access

   initial
   begin
      repeat (4) @(negedge mclk_i);
      arst_n_i = 1;
      for (int k = 0; k < 4; k++) pulse_evt(k);
      $display("test control events done");
      repeat (250) access($unsigned($random(seed)) % 8, ($random(seed) % 5) == 0,
         1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 0);
      $display("test random accesses done");
      cache_disable_control_bit_i = 1;
      repeat (2) @(negedge mclk_i);
      access(6, 0, 0, 0, 0, 0, 1);
      access(5, 0, 1, 0, 1, 0, 1);
      pulse_evt(2);
      access(6, 0, 0, 0, 0, 0, 0);
      cache_disable_control_bit_i = 0;
      $display("test cache disable done");
      complete_run();
   end

   // about 250 accesses of at most 62 cycles each, with margin
   initial
   begin
      #100000;
      err_total++;
      complete_run();
   end
endmodule : tb_memory_type_cache_policy

`default_nettype wire
